// ---- design/cse_alu.sv ----
/*
  cse_alu: subtract and test datapath, producing result and new flags.
  assumes: caller decides when the result and flags are taken.
*/
`timescale 1ns/1ps
module cse_alu import cse_pkg::*; (
  input wire logic [7:0] a,
  input wire logic [7:0] m,
  input wire logic sub_en,
  input cse_flags_t flags_in,
  output logic [7:0] res,
  output cse_flags_t flags_out
);
  logic [8:0] diff;

  always_comb begin
    diff = {1'b0, a} - {1'b0, m};
    flags_out = flags_in;
    if (sub_en) begin
      res = diff[7:0];
      flags_out.n = diff[7];
      flags_out.z = (diff[7:0] == 8'h00);
      flags_out.c = diff[8];
    end else begin
      res = m;
      flags_out.n = m[7];
      flags_out.z = (m == 8'h00);
    end
  end
endmodule // cse_alu

// ---- design/cse_core.sv ----
/*
  cse_core: sequencer and registers for the instruction subset executor.
  assumes: memory reads are combinational on the registered address; writes
  take effect at the clock edge where wr is high.
*/
`timescale 1ns/1ps
module cse_core import cse_pkg::*; #(
  parameter logic [15:0] RESET_PC = 16'h0000,
  parameter logic [15:0] TRAP_VEC_HI = 16'hfffc,
  parameter logic [15:0] TRAP_VEC_LO = 16'hfffd
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] mem_rdata,
  output cse_mem_req_t mem_req,
  input wire logic wake_pin,
  output logic halted,
  output logic [7:0] acc,
  output logic [7:0] index,
  output logic [7:0] stack_ptr,
  output logic [15:0] prog_cnt,
  output cse_flags_t condition_flags_reg
);
  cse_state_t state_q;
  cse_mode_t mode_q;
  cse_mode_t mode_now;
  cse_mem_req_t req_q;
  cse_mem_req_t req_term;
  cse_flags_t flags_q;
  cse_flags_t alu_flags;
  logic [3:0] cyc_q;
  logic [3:0] need_q;
  logic [3:0] need_now;
  logic [3:0] cyc_term;
  logic [2:0] idx_q;
  logic [7:0] op_q;
  logic [7:0] hi_q;
  logic [7:0] a_q;
  logic [7:0] x_q;
  logic [7:0] sp_q;
  logic [15:0] pc_q;
  logic [15:0] pc_d;
  logic [7:0] cur_op;
  logic [7:0] alu_m;
  logic [7:0] alu_res;
  logic [7:0] push_data;
  logic bit_q;
  logic br_taken;
  logic fetching;
  logic last_cyc;
  logic alu_go;
  logic wake_s1;
  logic wake_s2;
  logic wake_s3;
  logic wake_q;
  cse_state_t state_term;

  assign fetching = (state_q == ST_FETCH);
  assign cur_op = fetching ? mem_rdata : op_q;
  assign mode_now = mode_of(mem_rdata);
  assign need_now = fetching ? cycles_of(mem_rdata) : need_q;
  assign last_cyc = (cyc_q == need_now - 4'h1);
  assign br_taken = bit_q ^ op_q[0];
  assign alu_m = (fetching && mem_rdata == OP_PROBE_IDX) ? x_q : (fetching ? a_q : mem_rdata);
  assign alu_go = (fetching && (mem_rdata == OP_PROBE_ACC || mem_rdata == OP_PROBE_IDX)) ||
                  (state_q == ST_OPR1 && mode_q == MD_IMM) || (state_q == ST_MEM);

  // closing an instruction: pad to its full length, then refetch
  assign state_term = last_cyc ? ST_FETCH : ST_PAD;
  assign cyc_term = last_cyc ? 4'h0 : cyc_q + 4'h1;
  assign req_term = '{addr: pc_d, rd: last_cyc, wr: 1'b0, wdata: 8'h00};

  cse_alu u_alu (
    .a(a_q),
    .m(alu_m),
    .sub_en(is_sub(cur_op)),
    .flags_in(flags_q),
    .res(alu_res),
    .flags_out(alu_flags)
  );

  // next program counter
  always_comb begin
    pc_d = pc_q;
    case (state_q)
      ST_FETCH, ST_OPR1, ST_OPR2: pc_d = pc_q + 16'h0001;
      ST_BTB_REL: pc_d = pc_q + 16'h0001 + (br_taken ? {{8{mem_rdata[7]}}, mem_rdata} : 16'h0000);
      ST_VECH: pc_d = {mem_rdata, pc_q[7:0]};
      ST_VECL: pc_d = {pc_q[15:8], mem_rdata};
      default: pc_d = pc_q;
    endcase
  end

  // stacking order after the low counter byte
  always_comb begin
    case (idx_q)
      3'h0: push_data = pc_q[15:8];
      3'h1: push_data = x_q;
      3'h2: push_data = a_q;
      default: push_data = {FLAGS_FILL, flags_q};
    endcase
  end

  // wake pin synchroniser
  always_ff @(posedge clk) begin
    if (rst) begin
      wake_s1 <= 1'b0;
      wake_s2 <= 1'b0;
      wake_s3 <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      wake_s1 <= wake_pin;
      wake_s2 <= wake_s1;
      wake_s3 <= wake_s2;
      if (wake_s2 == wake_s3) begin
        wake_q <= wake_s3;
      end
    end
  end

  // sequencer and bus request
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_FETCH;
      mode_q <= MD_IMPL;
      cyc_q <= 4'h0;
      need_q <= 4'h0;
      op_q <= 8'h00;
      hi_q <= 8'h00;
      idx_q <= 3'h0;
      bit_q <= 1'b0;
      req_q <= '{addr: RESET_PC, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
    end else begin
      cyc_q <= cyc_q + 4'h1;
      case (state_q)
        ST_FETCH: begin
          op_q <= mem_rdata;
          mode_q <= mode_now;
          need_q <= need_now;
          if (mem_rdata == OP_SOFT_TRAP) begin
            state_q <= ST_PUSH;
            idx_q <= 3'h0;
            req_q <= '{addr: {STACK_PAGE, sp_q}, rd: 1'b0, wr: 1'b1, wdata: pc_d[7:0]};
          end else if (mem_rdata == OP_WAIT) begin
            state_q <= ST_HALT;
            req_q.rd <= 1'b0;
          end else if (mode_now == MD_IMPL) begin
            state_q <= state_term;
            cyc_q <= cyc_term;
            req_q <= req_term;
          end else if (mode_now == MD_IX) begin
            state_q <= ST_MEM;
            req_q <= '{addr: {8'h00, x_q}, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
          end else begin
            state_q <= ST_OPR1;
            req_q <= '{addr: pc_d, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
          end
        end
        ST_OPR1: begin
          case (mode_q)
            MD_IMM: begin
              state_q <= state_term;
              cyc_q <= cyc_term;
              req_q <= req_term;
            end
            MD_DIR: begin
              state_q <= ST_MEM;
              req_q.addr <= {DIRECT_PAGE, mem_rdata};
            end
            MD_BTB: begin
              state_q <= ST_BTB_MEM;
              req_q.addr <= {DIRECT_PAGE, mem_rdata};
            end
            MD_IDX_SHORT: begin
              state_q <= ST_MEM;
              req_q.addr <= ea_add(x_q, {8'h00, mem_rdata});
            end
            default: begin
              state_q <= ST_OPR2;
              hi_q <= mem_rdata;
              req_q.addr <= pc_d;
            end
          endcase
        end
        ST_OPR2: begin
          state_q <= ST_MEM;
          if (mode_q == MD_ABS) begin
            req_q.addr <= {hi_q, mem_rdata};
          end else begin
            req_q.addr <= ea_add(x_q, {hi_q, mem_rdata});
          end
        end
        ST_BTB_MEM: begin
          bit_q <= mem_rdata[op_q[3:1]];
          state_q <= ST_BTB_REL;
          req_q.addr <= pc_q;
        end
        ST_PUSH: begin
          idx_q <= idx_q + 3'h1;
          if (idx_q == PUSH_LAST) begin
            state_q <= ST_VECH;
            req_q <= '{addr: TRAP_VEC_HI, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
          end else begin
            req_q <= '{addr: {STACK_PAGE, sp_q - 8'h01}, rd: 1'b0, wr: 1'b1, wdata: push_data};
          end
        end
        ST_VECH: begin
          state_q <= ST_VECL;
          req_q.addr <= TRAP_VEC_LO;
        end
        ST_MEM, ST_BTB_REL, ST_VECL: begin
          state_q <= state_term;
          cyc_q <= cyc_term;
          req_q <= req_term;
        end
        ST_PAD: begin
          state_q <= state_term;
          cyc_q <= cyc_term;
          req_q.rd <= last_cyc;
        end
        ST_HALT: begin
          cyc_q <= 4'h0;
          if (wake_q) begin
            state_q <= ST_FETCH;
            req_q <= '{addr: pc_q, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
          end
        end
        default: begin
          state_q <= ST_FETCH;
          cyc_q <= 4'h0;
          req_q <= '{addr: pc_q, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
        end
      endcase
    end
  end

  // architectural registers
  always_ff @(posedge clk) begin
    if (rst) begin
      a_q <= 8'h00;
      x_q <= 8'h00;
      sp_q <= RST_SP;
      pc_q <= RESET_PC;
      flags_q <= RST_FLAGS;
    end else begin
      pc_q <= pc_d;
      if (fetching && mem_rdata == OP_ACC_TO_IDX) begin
        x_q <= a_q;
      end
      if (fetching && mem_rdata == OP_IDX_TO_ACC) begin
        a_q <= x_q;
      end
      if (fetching && mem_rdata == OP_WAIT) begin
        flags_q.i <= 1'b0;
      end
      if (alu_go) begin
        flags_q <= alu_flags;
        if (is_sub(cur_op)) begin
          a_q <= alu_res;
        end
      end
      if (state_q == ST_BTB_MEM) begin
        flags_q.c <= mem_rdata[op_q[3:1]];
      end
      if (state_q == ST_PUSH) begin
        sp_q <= sp_q - 8'h01;
        if (idx_q == PUSH_LAST) begin
          flags_q.i <= 1'b1;
        end
      end
    end
  end

  assign mem_req = req_q;
  assign halted = (state_q == ST_HALT);
  assign acc = a_q;
  assign index = x_q;
  assign stack_ptr = sp_q;
  assign prog_cnt = pc_q;
  assign condition_flags_reg = flags_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence trap_pushes;
    (mem_req.wr && mem_req.wdata == pc_q[7:0]) ##1 (mem_req.wr)[*4] ##1
      (!mem_req.wr && mem_req.rd && mem_req.addr == TRAP_VEC_HI && flags_q.i);
  endsequence

  sequence btb_fetches;
    (state_q == ST_OPR1 && mem_req.addr == pc_q) ##1 (state_q == ST_BTB_MEM) ##1
      (state_q == ST_BTB_REL && mem_req.addr == pc_q) ##1 (state_q == ST_PAD) ##1 fetching;
  endsequence

  acc_move_a: assert property (fetching && mem_rdata == OP_ACC_TO_IDX |=>
    x_q == $past(a_q) && flags_q == $past(flags_q) ##1 fetching) else $error("index transfer wrong");
  index_move_a: assert property (fetching && mem_rdata == OP_IDX_TO_ACC |=>
    a_q == $past(x_q) && flags_q == $past(flags_q) ##1 fetching) else $error("acc transfer wrong");
  probe_flags_a: assert property (state_q == ST_MEM && is_probe(op_q) |=>
    flags_q.n == $past(mem_rdata[7]) && flags_q.z == ($past(mem_rdata) == 8'h00) &&
    flags_q.c == $past(flags_q.c) && a_q == $past(a_q)) else $error("probe flags wrong");
  probe_len_a: assert property (fetching && mem_rdata == OP_PROBE_DIR |=>
    !fetching [*3] ##1 fetching) else $error("probe length wrong");
  trap_stack_a: assert property (fetching && mem_rdata == OP_SOFT_TRAP |=> trap_pushes)
    else $error("trap stacking wrong");
  trap_sp_a: assert property (fetching && mem_rdata == OP_SOFT_TRAP |->
    ##6 sp_q == $past(sp_q, 6) - 8'h05) else $error("trap stack pointer wrong");
  trap_len_a: assert property (fetching && mem_rdata == OP_SOFT_TRAP |-> ##10 fetching)
    else $error("trap length wrong");
  vec_load_a: assert property (state_q == ST_VECH |=> pc_q[15:8] == $past(mem_rdata) ##1
    pc_q[7:0] == $past(mem_rdata) && mem_req.addr == pc_q) else $error("vector load wrong");
  long_index_a: assert property (state_q == ST_OPR2 && mode_q == MD_IDX_LONG |=>
    mem_req.rd && mem_req.addr == {$past(hi_q), $past(mem_rdata)} + {8'h00, $past(x_q)})
    else $error("long indexed address wrong");
  abs_address_a: assert property (state_q == ST_OPR2 && mode_q == MD_ABS |=>
    mem_req.rd && mem_req.addr == {$past(hi_q), $past(mem_rdata)}) else $error("absolute address wrong");
  short_index_a: assert property (state_q == ST_OPR1 && mode_q == MD_IDX_SHORT |=>
    mem_req.addr == {8'h00, $past(mem_rdata)} + {8'h00, $past(x_q)}) else $error("short indexed address wrong");
  btb_order_a: assert property (fetching && mode_now == MD_BTB |=> btb_fetches)
    else $error("bit branch fetch order wrong");
  rel_target_a: assert property (state_q == ST_BTB_REL && br_taken |=>
    pc_q == $past(pc_q) + 16'h0001 + {{8{$past(mem_rdata[7])}}, $past(mem_rdata)})
    else $error("branch target wrong");
  sub_result_a: assert property (state_q == ST_MEM && is_sub(op_q) |=>
    a_q == $past(a_q) - $past(mem_rdata) && flags_q.c == ($past(mem_rdata) > $past(a_q)) &&
    flags_q.h == $past(flags_q.h) && flags_q.i == $past(flags_q.i)) else $error("subtract wrong");
  wait_halt_a: assert property (fetching && mem_rdata == OP_WAIT |=>
    halted && !flags_q.i && !mem_req.rd) else $error("wait did not halt");
endmodule // cse_core

// ---- include/cse_pkg.sv ----
/*
  cse_pkg: shared types, opcodes, cycle counts and decode helpers for the
  instruction subset executor.
  assumes: one 8-bit data bus with a 16-bit address, stack and direct page in page zero.
*/
package cse_pkg;

  typedef enum logic [3:0] {
    ST_FETCH   = 4'h0,
    ST_OPR1    = 4'h1,
    ST_OPR2    = 4'h2,
    ST_MEM     = 4'h3,
    ST_BTB_MEM = 4'h4,
    ST_BTB_REL = 4'h5,
    ST_PUSH    = 4'h6,
    ST_VECH    = 4'h7,
    ST_VECL    = 4'h8,
    ST_PAD     = 4'h9,
    ST_HALT    = 4'ha
  } cse_state_t;

  typedef enum logic [2:0] {
    MD_IMPL = 3'h0,
    MD_IMM = 3'h1,
    MD_DIR = 3'h2,
    MD_ABS = 3'h3,
    MD_IDX_LONG = 3'h4,
    MD_IDX_SHORT = 3'h5,
    MD_IX  = 3'h6,
    MD_BTB = 3'h7
  } cse_mode_t;

  typedef struct packed {
    logic h;
    logic i;
    logic n;
    logic z;
    logic c;
  } cse_flags_t;

  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } cse_mem_req_t;

  localparam logic [7:0] OP_ACC_TO_IDX = 8'h97;
  localparam logic [7:0] OP_IDX_TO_ACC = 8'h9f;
  localparam logic [7:0] OP_SOFT_TRAP = 8'h83;
  localparam logic [7:0] OP_WAIT = 8'h8f;
  localparam logic [7:0] OP_PROBE_DIR = 8'h3d;
  localparam logic [7:0] OP_PROBE_ACC = 8'h4d;
  localparam logic [7:0] OP_PROBE_IDX = 8'h5d;
  localparam logic [3:0] OP_PROBE_LO = 4'hd;
  localparam logic [3:0] OP_SUB_LO = 4'h0;

  localparam logic [3:0] CYC_XFER = 4'h2;
  localparam logic [3:0] CYC_WAIT = 4'h2;
  localparam logic [3:0] CYC_TRAP = 4'ha;
  localparam logic [3:0] CYC_BTB = 4'h5;
  localparam logic [3:0] CYC_OTHER = 4'h2;

  localparam logic [7:0] RST_SP = 8'hff;
  localparam logic [7:0] STACK_PAGE = 8'h00;
  localparam logic [7:0] DIRECT_PAGE = 8'h00;
  localparam logic [2:0] FLAGS_FILL = 3'h7;
  localparam logic [2:0] PUSH_LAST = 3'h4;
  localparam cse_flags_t RST_FLAGS = '{h: 1'b0, i: 1'b1, n: 1'b0, z: 1'b0, c: 1'b0};

  function automatic logic is_sub(input logic [7:0] op);
    return (op[3:0] == OP_SUB_LO) && (op[7:4] >= 4'ha);
  endfunction

  function automatic logic is_probe(input logic [7:0] op);
    return (op[3:0] == OP_PROBE_LO) && (op[7:4] >= 4'h3) && (op[7:4] <= 4'h7);
  endfunction

  function automatic cse_mode_t mode_of(input logic [7:0] op);
    cse_mode_t m;
    m = MD_IMPL;
    if (op[7:4] == 4'h0) begin
      m = MD_BTB;
    end else if (is_sub(op) || is_probe(op)) begin
      case (op[7:4])
        4'h3, 4'hb: m = MD_DIR;
        4'ha: m = MD_IMM;
        4'hc: m = MD_ABS;
        4'hd: m = MD_IDX_LONG;
        4'h6, 4'he: m = MD_IDX_SHORT;
        4'h7, 4'hf: m = MD_IX;
        default: m = MD_IMPL;
      endcase
    end
    return m;
  endfunction

  function automatic logic [3:0] cycles_of(input logic [7:0] op);
    logic [3:0] n;
    n = CYC_OTHER;
    if (op == OP_ACC_TO_IDX || op == OP_IDX_TO_ACC) begin
      n = CYC_XFER;
    end else if (op == OP_WAIT) begin
      n = CYC_WAIT;
    end else if (op == OP_SOFT_TRAP) begin
      n = CYC_TRAP;
    end else if (op[7:4] == 4'h0) begin
      n = CYC_BTB;
    end else if (is_probe(op)) begin
      case (op[7:4])
        4'h3: n = 4'h4;
        4'h4, 4'h5: n = 4'h3;
        4'h6: n = 4'h5;
        default: n = 4'h4;
      endcase
    end else if (is_sub(op)) begin
      case (op[7:4])
        4'ha: n = 4'h2;
        4'hb: n = 4'h3;
        4'hc: n = 4'h4;
        4'hd: n = 4'h5;
        4'he: n = 4'h4;
        default: n = 4'h3;
      endcase
    end
    return n;
  endfunction

  function automatic logic [15:0] ea_add(input logic [7:0] x, input logic [15:0] off);
    return off + {8'h00, x};
  endfunction

endpackage

// ---- tb/cse_mem_model.sv ----
/*
  cse_mem_model: program memory and stack ram on the core's bus.
  assumes: reads answer in the same cycle, writes land at the clock edge, no wait states.
*/
`timescale 1ns/1ps
module cse_mem_model import cse_pkg::*; (
  input wire logic clk,
  input wire cse_mem_req_t mem_req,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_q = 8'h00;

  // unselected bus shows the inverse of the last byte
  always_comb begin
    mem_rdata = mem_req.rd ? mem[mem_req.addr] : ~last_q;
  end

  always @(posedge clk) begin
    if (mem_req.rd) begin
      last_q <= mem[mem_req.addr];
    end
  end

  always @(posedge clk) begin
    if (mem_req.wr) begin
      mem[mem_req.addr] <= mem_req.wdata;
    end
  end

  task automatic clear();
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'h00;
    end
  endtask
endmodule // cse_mem_model

// ---- tb/tb_top.sv ----
/*
  tb_top: self-checking bench for cse_core with a memory model.
  assumes: core fetches from address zero after reset, trap vector at the core defaults.
*/
`timescale 1ns/1ps
module tb_top import cse_pkg::*; ;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wake_pin = 1'b0;
  logic [7:0] mem_rdata;
  cse_mem_req_t mem_req;
  logic halted;
  logic [7:0] acc, index, stack_ptr;
  logic [15:0] prog_cnt;
  cse_flags_t flags;
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;

  always #2.5 clk = ~clk;
  always @(posedge clk) cyc <= rst ? 0 : cyc + 1;

  cse_core i_cse_core (.clk(clk), .rst(rst), .mem_rdata(mem_rdata), .mem_req(mem_req), .wake_pin(wake_pin),
    .halted(halted), .acc(acc), .index(index), .stack_ptr(stack_ptr), .prog_cnt(prog_cnt),
    .condition_flags_reg(flags));
  cse_mem_model u_mem (.clk(clk), .mem_req(mem_req), .mem_rdata(mem_rdata));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic load(input logic [7:0] b[$]);
    u_mem.clear();
    foreach (b[k]) u_mem.mem[k] = b[k];
  endtask

  task automatic boot();
    rst = 1'b1;
    repeat (12) @(negedge clk);
    rst = 1'b0;
  endtask

  task automatic at(input int n);
    while (cyc < n) @(negedge clk);
  endtask

  // read request at a given cycle
  task automatic bus(input int n, input logic [15:0] a);
    at(n);
    check("bus", {mem_req.rd, mem_req.wr, mem_req.addr}, {1'b1, 1'b0, a});
  endtask

  task automatic s_xfer();
    load('{8'ha0, 8'h5b, 8'h97, 8'ha0, 8'h01, 8'h9f});
    boot();
    bus(4, 16'h0003);
    check("index", index, 8'ha5);
    check("flags", flags, 5'b01101);
    bus(8, 16'h0006);
    check("acc", acc, 8'ha5);
    check("flags", flags, 5'b01100);
  endtask

  task automatic s_probe();
    load('{8'ha0, 8'h01, 8'h4d, 8'h5d, 8'h3d, 8'h10, 8'h6d, 8'h20, 8'h7d});
    u_mem.mem[16'h0010] = 8'h80;
    boot();
    bus(5, 16'h0003);
    check("flags", flags, 5'b01101);
    bus(8, 16'h0004);
    check("flags", flags, 5'b01011);
    bus(10, 16'h0010);
    bus(12, 16'h0006);
    check("flags", flags, 5'b01101);
    bus(14, 16'h0020);
    bus(17, 16'h0008);
    check("flags", flags, 5'b01011);
    bus(18, 16'h0000);
    bus(21, 16'h0009);
    check("flags", flags, 5'b01101);
    check("acc", acc, 8'hff);
  endtask

  task automatic s_modes();
    load('{8'ha0, 8'hf0, 8'h97, 8'hc0, 8'h12, 8'h34, 8'hd0, 8'h12, 8'h00, 8'he0, 8'h30, 8'hf0, 8'hb0, 8'h50});
    u_mem.mem[16'h1234] = 8'h03;
    u_mem.mem[16'h1210] = 8'h01;
    u_mem.mem[16'h0040] = 8'h02;
    u_mem.mem[16'h0010] = 8'h0a;
    u_mem.mem[16'h0050] = 8'h01;
    boot();
    bus(5, 16'h0004);
    bus(6, 16'h0005);
    bus(7, 16'h1234);
    bus(8, 16'h0006);
    check("acc", acc, 8'h0d);
    bus(11, 16'h1210);
    bus(13, 16'h0009);
    check("acc", acc, 8'h0c);
    bus(15, 16'h0040);
    bus(17, 16'h000b);
    check("acc", acc, 8'h0a);
    bus(18, 16'h0010);
    bus(20, 16'h000c);
    check("flags", {acc, flags}, {8'h00, 5'b01010});
    bus(22, 16'h0050);
    bus(23, 16'h000e);
    check("flags", {acc, flags}, {8'hff, 5'b01101});
  endtask

  task automatic s_branch();
    load('{8'h00, 8'h20, 8'h03, 8'h00, 8'h00, 8'h00, 8'h03, 8'h20, 8'hf7, 8'h02, 8'h20, 8'hf4});
    u_mem.mem[16'h0020] = 8'h03;
    boot();
    bus(1, 16'h0001);
    bus(2, 16'h0020);
    bus(3, 16'h0002);
    bus(5, 16'h0006);
    check("flags", flags, 5'b01001);
    bus(10, 16'h0009);
    bus(15, 16'h0000);
    check("pc", prog_cnt, 16'h0000);
  endtask

  task automatic s_wait_trap();
    int base;
    load('{8'ha0, 8'hf0, 8'h97, 8'ha0, 8'h01, 8'h8f, 8'h83});
    u_mem.mem[16'hfffc] = 8'h12;
    u_mem.mem[16'hfffd] = 8'h34;
    boot();
    at(7);
    check("halted", halted, 1'b1);
    check("flags", flags, 5'b00000);
    at(11);
    check("halted", halted, 1'b1);
    wake_pin = 1'b1;
    for (int k = 0; k < 10 && !(mem_req.rd === 1'b1 && mem_req.addr === 16'h0006); k++) @(negedge clk);
    wake_pin = 1'b0;
    base = cyc;
    bus(base, 16'h0006);
    check("halted", halted, 1'b0);
    at(base + 1);
    check("push", {mem_req.wr, mem_req.addr, mem_req.wdata}, {1'b1, 16'h00ff, 8'h07});
    bus(base + 6, 16'hfffc);
    bus(base + 7, 16'hfffd);
    bus(base + 10, 16'h1234);
    check("pc", prog_cnt, 16'h1234);
    check("sp", stack_ptr, 8'hfa);
    check("flags", flags, 5'b01000);
    check("stack", {u_mem.mem[255], u_mem.mem[254], u_mem.mem[253]}, 24'h070010);
    check("stack", {u_mem.mem[252], u_mem.mem[251]}, 16'h0fe0);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (2000) @(posedge clk);
    fails++;
    conclude();
  end

  initial begin
    s_xfer();
    s_probe();
    s_modes();
    s_branch();
    s_wait_trap();
    conclude();
  end
endmodule // tb_top
